//--- verilog/hcl_pkg.sv
/*
  Constants and carrier types for the hardware configuration lock registers.
  Assumes a serial frame decoder on clk_sys that hands over whole byte writes.
*/
package hcl_pkg;

  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;

  // Register addresses
  localparam logic [6:0] ADDR_RESET_THERMAL_LOCK = 7'h0e;
  localparam logic [6:0] ADDR_PUMP_PEAK_LOCK     = 7'h0f;

  // First control register fields
  localparam int unsigned C1_UV_HYS_BIT   = 7;
  localparam int unsigned C1_THERMAL_BIT  = 5;
  localparam int unsigned C1_RST_DEL_BIT  = 4;
  localparam int unsigned C1_LOCK0_BIT    = 3;
  localparam logic [7:0]  C1_WRITE_MASK   = 8'h00_b8;
  localparam logic [7:0]  C1_LOCK1_MASK   = 8'h00_b0;
  localparam logic [7:0]  C1_POR_VALUE    = 8'h00_00;

  // Second control register fields
  localparam int unsigned C2_FREQ_MSB     = 7;
  localparam int unsigned C2_FREQ_LSB     = 5;
  localparam int unsigned C2_PEAK_BIT     = 4;
  localparam int unsigned C2_SSM_MSB      = 3;
  localparam int unsigned C2_SSM_LSB      = 2;
  localparam int unsigned C2_LOCK1_BIT    = 0;
  localparam logic [7:0]  C2_WRITE_MASK   = 8'h00_fd;
  localparam logic [7:0]  C2_LOCK1_MASK   = 8'h00_fd;
  localparam logic [7:0]  C2_POR_VALUE    = 8'h00_40;

  // Charge pump oscillator codes
  localparam logic [2:0]  FREQ_1M8        = 3'h0;
  localparam logic [2:0]  FREQ_2M0        = 3'h1;
  localparam logic [2:0]  FREQ_2M2        = 3'h2;
  localparam logic [2:0]  FREQ_2M4        = 3'h3;

  // Spread spectrum codes
  localparam logic [1:0]  SSM_OFF         = 2'h0;

  // Severe overtemperature extension
  localparam logic [4:0]  THERMAL_EVENT_LIMIT = 5'h10;
  localparam int unsigned THERMAL_EXTEND_FACTOR = 64;

  typedef struct packed {
    logic             valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } hcl_write_t;

  typedef struct packed {
    logic uv_reset_hysteresis_sel;
    logic thermal_wait_extend_sel;
    logic reset_delay_sel;
    logic lock0;
  } hcl_ctrl1_t;

  typedef struct packed {
    logic [2:0] pump_osc_freq_sel;
    logic       supply_peak_threshold_sel;
    logic [1:0] spread_spectrum_rate;
    logic       lock1;
  } hcl_ctrl2_t;

endpackage : hcl_pkg

//--- verilog/hcl_pin_sync.sv
/*
  Three-stage synchroniser for an asynchronous pin, with a rising edge pulse.
  Assumes the pin level is stable for at least three clk_sys periods.
*/
module hcl_pin_sync (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_pulse
);

  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= 1'b1;
      stage2_reg <= 1'b1;
      stage3_reg <= 1'b1;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // Idle high, so reset looks like a deselected chip
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      level_out  <= 1'b1;
      rise_pulse <= 1'b0;
    end else begin
      rise_pulse <= 1'b0;
      if (stage2_reg == stage3_reg && stage3_reg != level_out) begin
        level_out  <= stage3_reg;
        rise_pulse <= stage3_reg;
      end
    end
  end

endmodule : hcl_pin_sync

//--- verilog/hcl_regs.sv
/*
  Two hardware configuration registers with two lock levels.
  Assumes a frame decoder on clk_sys delivering byte writes and a read address,
  with the chip select pin passed in raw. rst_n is the power-on reset.
*/
// Functional notes
// - First register at 0x0e, lock-dependent reset values
// - Reserved bits read zero, writes ignored
// - Hysteresis bit selects highest release threshold
// - Thermal wait x64 after more than sixteen events
// - Reset delay bit: zero extended, one reduced
// - Lock0 freezes pump enable and pin config
// - Soft reset spares lock-protected bits
// - Lock1 governs all other lockable bits
// - Second register at 0x0f, power-on 0x40
// - Pump frequency codes, default 2.2 MHz
// - Peak bit selects low or high threshold
// - Spread spectrum off or three rates
// - Lock1 freezes bits until power-up
// - Lock1 effective at chip-select rise
// - Soft reset keeps lock1
// - Values kept after sleep or fail-safe
// - New configuration active at chip-select rise
module hcl_regs (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              chip_select_n,
  input  hcl_pkg::hcl_write_t    wr_req,
  input  wire logic [6:0]        rd_addr,
  input  wire logic              soft_reset,
  input  wire logic              restart,
  input  wire logic              severe_overtemp_event,
  input  wire logic              overtemp_sequence_end,
  output logic [7:0]             rd_data,
  output hcl_pkg::hcl_ctrl1_t    ctrl1,
  output hcl_pkg::hcl_ctrl2_t    ctrl2,
  output logic                   pump_cfg_locked,
  output logic                   pump_freq_reserved,
  output logic                   spread_spectrum_on,
  output logic                   thermal_wait_x64
);

  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl2_reg;
  logic [7:0] pend1_reg;
  logic [7:0] pend2_reg;
  logic       pend1_valid_reg;
  logic       pend2_valid_reg;
  logic [4:0] overtemp_count_reg;
  logic       cs_level;
  logic       cs_rise;
  logic       lock1;

  hcl_pin_sync u_cs_sync (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .pin_in     (chip_select_n),
    .level_out  (cs_level),
    .rise_pulse (cs_rise)
  );

  // Locked bits come from the old value, writable ones from the new
  function automatic logic [7:0] merge_write(
    input logic [7:0] old_val,
    input logic [7:0] new_val,
    input logic [7:0] writable
  );
    merge_write = (old_val & ~writable) | (new_val & writable);
  endfunction : merge_write

  assign lock1 = ctrl2_reg[hcl_pkg::C2_LOCK1_BIT];

  // Writes are staged during the frame and committed on deselect
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend1_reg       <= 8'h00_00;
      pend2_reg       <= 8'h00_00;
      pend1_valid_reg <= 1'b0;
      pend2_valid_reg <= 1'b0;
    end else if (cs_rise) begin
      pend1_valid_reg <= 1'b0;
      pend2_valid_reg <= 1'b0;
    end else if (wr_req.valid && !cs_level) begin
      if (wr_req.addr == hcl_pkg::ADDR_RESET_THERMAL_LOCK) begin
        pend1_reg       <= wr_req.data;
        pend1_valid_reg <= 1'b1;
      end
      if (wr_req.addr == hcl_pkg::ADDR_PUMP_PEAK_LOCK) begin
        pend2_reg       <= wr_req.data;
        pend2_valid_reg <= 1'b1;
      end
    end
  end

  // First control register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_reg <= hcl_pkg::C1_POR_VALUE;
    end else if (restart) begin
      ctrl1_reg <= ctrl1_reg;
    end else if (soft_reset) begin
      // Locked bits take their restart value, which is the held value
      ctrl1_reg <= lock1 ? ctrl1_reg : hcl_pkg::C1_POR_VALUE;
    end else if (cs_rise && pend1_valid_reg) begin
      if (lock1) begin
        ctrl1_reg <= merge_write(ctrl1_reg, pend1_reg,
                                 hcl_pkg::C1_WRITE_MASK & ~hcl_pkg::C1_LOCK1_MASK);
      end else begin
        ctrl1_reg <= merge_write(ctrl1_reg, pend1_reg, hcl_pkg::C1_WRITE_MASK);
      end
    end
  end

  // Second control register; soft reset and restart both hold it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl2_reg <= hcl_pkg::C2_POR_VALUE;
    end else if (restart || soft_reset) begin
      ctrl2_reg <= ctrl2_reg;
    end else if (cs_rise && pend2_valid_reg && !lock1) begin
      ctrl2_reg <= merge_write(ctrl2_reg, pend2_reg, hcl_pkg::C2_WRITE_MASK);
    end
  end

  // Consecutive severe overtemperature events
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      overtemp_count_reg <= 5'h00;
    end else if (severe_overtemp_event) begin
      // Event beats end-of-sequence in the same cycle
      if (overtemp_count_reg <= hcl_pkg::THERMAL_EVENT_LIMIT) begin
        overtemp_count_reg <= overtemp_count_reg + 5'h01;
      end
    end else if (overtemp_sequence_end) begin
      overtemp_count_reg <= 5'h00;
    end
  end

  // Read port and decoded outputs, all registered
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data            <= 8'h00_00;
      ctrl1              <= '0;
      ctrl2              <= '0;
      pump_cfg_locked    <= 1'b0;
      pump_freq_reserved <= 1'b0;
      spread_spectrum_on <= 1'b0;
      thermal_wait_x64   <= 1'b0;
    end else begin
      unique case (rd_addr)
        hcl_pkg::ADDR_RESET_THERMAL_LOCK: rd_data <= ctrl1_reg & hcl_pkg::C1_WRITE_MASK;
        hcl_pkg::ADDR_PUMP_PEAK_LOCK:     rd_data <= ctrl2_reg & hcl_pkg::C2_WRITE_MASK;
        default:                          rd_data <= 8'h00_00;
      endcase
      ctrl1.uv_reset_hysteresis_sel   <= ctrl1_reg[hcl_pkg::C1_UV_HYS_BIT];
      ctrl1.thermal_wait_extend_sel   <= ctrl1_reg[hcl_pkg::C1_THERMAL_BIT];
      ctrl1.reset_delay_sel           <= ctrl1_reg[hcl_pkg::C1_RST_DEL_BIT];
      ctrl1.lock0                     <= ctrl1_reg[hcl_pkg::C1_LOCK0_BIT];
      ctrl2.pump_osc_freq_sel         <= ctrl2_reg[hcl_pkg::C2_FREQ_MSB:hcl_pkg::C2_FREQ_LSB];
      ctrl2.supply_peak_threshold_sel <= ctrl2_reg[hcl_pkg::C2_PEAK_BIT];
      ctrl2.spread_spectrum_rate      <= ctrl2_reg[hcl_pkg::C2_SSM_MSB:hcl_pkg::C2_SSM_LSB];
      ctrl2.lock1                     <= lock1;
      // Pump enable and pin config live elsewhere; they obey this flag
      pump_cfg_locked    <= ctrl1_reg[hcl_pkg::C1_LOCK0_BIT];
      pump_freq_reserved <= ctrl2_reg[hcl_pkg::C2_FREQ_MSB];
      spread_spectrum_on <= ctrl2_reg[hcl_pkg::C2_SSM_MSB:hcl_pkg::C2_SSM_LSB] != hcl_pkg::SSM_OFF;
      thermal_wait_x64   <= ctrl1_reg[hcl_pkg::C1_THERMAL_BIT]
                            && (overtemp_count_reg > hcl_pkg::THERMAL_EVENT_LIMIT);
    end
  end

endmodule : hcl_regs

//--- bench/hcl_props.sv
/* Port checker for hcl_regs.
   Assumes chip select idles high through reset. */
module hcl_props (
  input wire logic          clk_sys,
  input wire logic          rst_n,
  input wire logic          chip_select_n,
  input wire logic [6:0]    rd_addr,
  input wire logic          soft_reset,
  input wire logic [7:0]    rd_data,
  input hcl_pkg::hcl_ctrl1_t ctrl1,
  input hcl_pkg::hcl_ctrl2_t ctrl2,
  input wire logic          pump_cfg_locked,
  input wire logic          pump_freq_reserved,
  input wire logic          spread_spectrum_on
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Long enough for any earlier commit to have landed
  sequence cs_held_low;
    !chip_select_n [*6];
  endsequence
  chk_unmapped_read: assert property (rd_addr != 7'h0e && rd_addr != 7'h0f |=> rd_data == 8'h00_00)
    else $error("unmapped read not zero");
  chk_ctrl1_read: assert property (rd_addr == 7'h0e |=> rd_data == {ctrl1.uv_reset_hysteresis_sel, 1'b0,
    ctrl1.thermal_wait_extend_sel, ctrl1.reset_delay_sel, ctrl1.lock0, 3'h0}) else $error("ctrl1 readback");
  chk_ctrl2_read: assert property (rd_addr == 7'h0f |=> rd_data == {ctrl2.pump_osc_freq_sel,
    ctrl2.supply_peak_threshold_sel, ctrl2.spread_spectrum_rate, 1'b0, ctrl2.lock1}) else $error("ctrl2 readback");
  chk_lock1_freeze: assert property (ctrl2.lock1 |=> $stable(ctrl2)) else $error("locked ctrl2 moved");
  chk_lock1_ctrl1: assert property (ctrl2.lock1 |=> $stable({ctrl1.uv_reset_hysteresis_sel,
    ctrl1.thermal_wait_extend_sel, ctrl1.reset_delay_sel})) else $error("locked ctrl1 moved");
  chk_lock0_flag: assert property (pump_cfg_locked == ctrl1.lock0) else $error("lock0 flag");
  chk_freq_flag: assert property (pump_freq_reserved == ctrl2.pump_osc_freq_sel[2]) else $error("freq flag");
  chk_spread_flag: assert property (spread_spectrum_on == (ctrl2.spread_spectrum_rate != 2'h0))
    else $error("spread flag");
  chk_cs_low_hold: assert property (cs_held_low |-> $stable(ctrl2)) else $error("ctrl2 moved in frame");
  chk_soft_clear: assert property (soft_reset && !ctrl2.lock1 |-> ##[1:2] ctrl1 == '0)
    else $error("soft reset kept ctrl1");
endmodule : hcl_props

bind hcl_regs hcl_props u_props (.clk_sys, .rst_n, .chip_select_n, .rd_addr, .soft_reset, .rd_data, .ctrl1,
  .ctrl2, .pump_cfg_locked, .pump_freq_reserved, .spread_spectrum_on);

//--- bench/hcl_host.sv
/* Host model: serial frames as decoded byte writes.
   Assumes frame() is called from the bench's main sequence. */
module hcl_host (
  input wire logic           clk_sys,
  output logic               chip_select_n,
  output hcl_pkg::hcl_write_t wr_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    chip_select_n = 1'b1;
    wr_req = '0;
  end
  // Caller clears lock0 before pump settings change
  task automatic frame(input logic [6:0] a, input logic [7:0] d, input logic sel);
    @(negedge clk_sys);
    chip_select_n = !sel;
    repeat (5) @(negedge clk_sys);
    wr_req = '{valid: 1'b1, addr: a, data: d};
    @(negedge clk_sys);
    wr_req.valid = 1'b0;
    wr_req.data = ~d;
    repeat (2) @(negedge clk_sys);
    chip_select_n = 1'b1;
    repeat (10) @(negedge clk_sys);
  endtask : frame
endmodule : hcl_host

//--- bench/tb.sv
/* Bench for hcl_regs: writes, locks, resets, thermal count.
   Assumes hcl_host as frame source and the bound checker. */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst_n, soft_reset, restart, sev, seq_end, chip_select_n;
  logic [6:0] rd_addr;
  logic [7:0] rd_data, m1, m2, d;
  logic lk, pump_cfg_locked, pump_freq_reserved, spread_spectrum_on, thermal_wait_x64;
  hcl_pkg::hcl_write_t wr_req;
  hcl_pkg::hcl_ctrl1_t ctrl1;
  hcl_pkg::hcl_ctrl2_t ctrl2;
  int miscompares, cmp_count, cycles;
  hcl_host host (.clk_sys, .chip_select_n, .wr_req);
  hcl_regs DUT (.clk_sys, .rst_n, .chip_select_n, .wr_req, .rd_addr, .soft_reset, .restart,
    .severe_overtemp_event(sev), .overtemp_sequence_end(seq_end), .rd_data, .ctrl1, .ctrl2,
    .pump_cfg_locked, .pump_freq_reserved, .spread_spectrum_on, .thermal_wait_x64);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_sim();
    end
  end
  function automatic logic [7:0] exp1(logic [7:0] old, logic [7:0] v, logic lock);
    return lock ? ((old & 8'h00_b0) | (v & 8'h00_08)) : (v & 8'h00_b8);
  endfunction : exp1
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    rd_addr = a;
    @(negedge clk_sys);
    check(rd_data, e);
  endtask : rdc
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    host.frame(a, v, 1'b1);
    if (a == 7'h0e) m1 = exp1(m1, v, lk);
    else m2 = lk ? m2 : (v & 8'h00_fd);
    lk = m2[0];
  endtask : wr
  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask : pulse
  task automatic por();
    rst_n = 1'b0;
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    m1 = 8'h00_00;
    m2 = 8'h00_40;
    lk = 1'b0;
  endtask : por
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  initial begin
    {soft_reset, restart, sev, seq_end, rd_addr, miscompares, cmp_count, cycles} = '0;
    void'($urandom(39279));
    por();
    rdc(7'h0e, 8'h00_00);
    rdc(7'h0f, 8'h00_40);
    // Power-on word 0x40 puts code 010 in the frequency field
    check({ctrl2.pump_osc_freq_sel, 5'h00}, 8'h00_40);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom());
      wr(7'h0e, d);
      wr(7'h0f, {d[7:1], 1'b0} ^ {i[2:0], i[0], i[1:0], 2'h0});
      rdc(7'h0e, m1);
      rdc(7'h0f, m2);
      rdc({1'b1, d[5:0]}, 8'h00_00);
      check({4'h0, ctrl1}, {4'h0, m1[7], m1[5:3]});
      check({1'b0, ctrl2}, {1'b0, m2[7:2], m2[0]});
      check({5'h00, pump_cfg_locked, pump_freq_reserved, spread_spectrum_on},
            {5'h00, m1[3], m2[7], m2[3:2] != 2'h0});
    end
    $display("test random_writes done");
    host.frame(7'h0e, 8'h00_ff, 1'b0);
    rdc(7'h0e, m1);
    wr(7'h0e, 8'h00_20);
    repeat (16) pulse(sev);
    check(8'(thermal_wait_x64), 8'h00_00);
    pulse(sev);
    check(8'(thermal_wait_x64), 8'h00_01);
    pulse(seq_end);
    check(8'(thermal_wait_x64), 8'h00_00);
    // Extension select clear: the count alone must not extend the wait
    wr(7'h0e, 8'h00_00);
    repeat (17) pulse(sev);
    check(8'(thermal_wait_x64), 8'h00_00);
    pulse(seq_end);
    $display("test thermal done");
    wr(7'h0e, 8'h00_f8);
    pulse(soft_reset);
    rdc(7'h0e, 8'h00_00);
    rdc(7'h0f, m2);
    wr(7'h0e, 8'h00_b0);
    pulse(restart);
    rdc(7'h0e, m1);
    rdc(7'h0f, m2);
    wr(7'h0f, 8'h00_e7);
    rdc(7'h0f, 8'h00_e5);
    wr(7'h0e, 8'h00_08);
    rdc(7'h0e, 8'h00_b8);
    wr(7'h0f, 8'h00_00);
    rdc(7'h0f, 8'h00_e5);
    pulse(soft_reset);
    rdc(7'h0e, 8'h00_b8);
    rdc(7'h0f, 8'h00_e5);
    $display("test locks done");
    por();
    rdc(7'h0f, 8'h00_40);
    wr(7'h0f, 8'h00_10);
    rdc(7'h0f, 8'h00_10);
    $display("test power_on done");
    end_sim();
  end
endmodule : tb
